// >>> inc/fsr_map.svh
// Register map, status bits, timing figures of the seek and sector read sequencer
// Assumes a 25 MHz clock; times in microseconds, counts in revolutions, step pulses, bytes or sectors
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH
`define FSR_CMD 8'h00
`define FSR_STAT 8'h04
`define FSR_TRK 8'h08
`define FSR_SEC 8'h0C
`define FSR_DAT 8'h10
`define FSR_CFG 8'h14
`define FSR_B_BUSY 0
`define FSR_B_DRQ 1
`define FSR_B_LOST 2
`define FSR_B_CRC 3
`define FSR_B_RNF 4
`define FSR_B_DEL 5
`define FSR_B_MOT 7
`define FSR_CLK_MHZ 25
`define FSR_STEP_DD_US 4
`define FSR_STEP_SD_US 8
`define FSR_DIR_SU_US 24
`define FSR_SETTLE_US 30000
`define FSR_RATE0_US 6000
`define FSR_RATE1_US 12000
`define FSR_RATE2_US 20000
`define FSR_RATE3_US 30000
`define FSR_SPIN_REVS 4'h6
`define FSR_IDLE_REVS 4'h9
`define FSR_VFY_REVS 4'h5
`define FSR_ID_REVS 4'h4
`define FSR_DAM_REVS 4'h5
`define FSR_RST_MAX 8'hFF
`define FSR_WIN_SD 6'h1E
`define FSR_WIN_DD 6'h2B
`define FSR_SPT_RST 8'h10
`endif

// >>> inc/fsr_pkg.sv
// Types of the seek and sector read sequencer
// Assumes nothing beyond the map header
package fsr_pkg;
    typedef enum logic [11:0] {
        S_IDLE = 12'h001, S_SPIN = 12'h002, S_START = 12'h004, S_DIRSU = 12'h008,
        S_PULSE = 12'h010, S_RATE = 12'h020, S_SETTLE = 12'h040, S_VERIFY = 12'h080,
        S_SEARCH = 12'h100, S_DAM = 12'h200, S_DATA = 12'h400, S_DONE = 12'h800
    } fsr_state_t;
    // Decoded stream from the on-chip data separator, same clock
    typedef struct packed {
        logic id_stb;
        logic [7:0] id_trk;
        logic [7:0] id_sec;
        logic id_crc_ok;
        logic mark_stb;
        logic mark_deleted;
        logic byte_stb;
        logic [7:0] byte_data;
        logic end_stb;
        logic end_crc_ok;
    } fsr_rd_t;
endpackage

// >>> test/fsr_drive_model.sv
// Drive and data separator model: head, track zero, index, ID and data stream
// Assumes one track per step pulse; the disk position runs always, index and data appear only while the motor is on
`timescale 1ns/1ps
module fsr_drive_model import fsr_pkg::*; #(
    parameter int REV = 2000,
    parameter int SPT = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic step_pulse,
    input wire logic step_dir,
    input wire logic spindle_motor_on,
    input wire logic mark_del,
    input wire logic crc_bad,
    output logic index_pulse_n,
    output logic track_zero_sense_n,
    output fsr_rd_t rd,
    output int head,
    output int pulses,
    output int width,
    output int setup,
    output int gap
);
    int cyc, pos, sec, wcnt, dcnt, gcnt;
    logic last_step, last_dir;
    assign pos = cyc % 100;
    assign sec = cyc / 100 + 1;
    assign track_zero_sense_n = head != 0;
    assign index_pulse_n = !(spindle_motor_on && cyc < 4);
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cyc <= 0;
            head <= 3;
            pulses <= 0;
            {width, setup, gap, wcnt, dcnt, gcnt} <= '0;
            {last_step, last_dir} <= 2'h0;
            rd <= '0;
        end else begin
            cyc <= (cyc + 1) % REV;
            last_step <= step_pulse;
            last_dir <= step_dir;
            wcnt <= step_pulse ? wcnt + 1 : 0;
            dcnt <= step_dir != last_dir ? 0 : dcnt + 1;
            gcnt <= gcnt + 1;
            if (step_pulse && !last_step) begin
                head <= step_dir ? head + 1 : (head > 0 ? head - 1 : 0);
                pulses <= pulses + 1;
                setup <= dcnt;
                gap <= gcnt;
                gcnt <= 1;
            end
            if (!step_pulse && last_step)
                width <= wcnt;
            // Outside a strobe the byte_data and id_trk fields change every cycle, the others stay zero
            rd <= '{byte_data: ~8'(cyc), id_trk: 8'(cyc), default: '0};
            if (spindle_motor_on && sec <= SPT) begin
                case (pos)
                    10: rd <= '{id_stb: 1'h1, id_trk: 8'(head), id_sec: 8'(sec),
                        id_crc_ok: 1'h1, default: '0};
                    20: rd <= '{mark_stb: 1'h1, mark_deleted: mark_del, default: '0};
                    30, 40, 50, 60: rd <= '{byte_stb: 1'h1, byte_data: 8'(sec * 16 + pos / 10),
                        default: '0};
                    70: rd <= '{end_stb: 1'h1, end_crc_ok: !crc_bad, default: '0};
                    default: ;
                endcase
            end
        end
    end
endmodule // fsr_drive_model

// >>> test/fsr_seq_tb.sv
// Self-checking bench of the seek and sector read sequencer over AHB-Lite
// Assumes the drive model beside it; long delays shortened through parameters
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_seq_tb import fsr_pkg::*;;
    localparam int REV = 2000;
    localparam int R3 = 200;
    logic clk, rstn, hsel, hwrite, hready, hresp, mark_del, crc_bad, index_pulse_n;
    logic track_zero_sense_n, step_pulse, step_dir, spindle_motor_on;
    logic byte_transfer_request, completion_interrupt;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, d;
    fsr_rd_t rd;
    int head, pulses, width, setup, gap, err_count, n_compared, t;
    logic [7:0] cmds [3] = '{8'h58, 8'h78, 8'h38};
    logic [7:0] trks [3] = '{8'h06, 8'h05, 8'h04};
    logic dirs [3] = '{1'h1, 1'h0, 1'h0};
    fsr_seq #(.SETTLE_CYC(200), .RATE0_CYC(100), .RATE1_CYC(120), .RATE2_CYC(150),
        .RATE3_CYC(R3)) u_dut (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout(hready), .hresp, .index_pulse_n, .track_zero_sense_n,
        .rd, .step_pulse, .step_dir, .spindle_motor_on, .byte_transfer_request,
        .completion_interrupt);
    fsr_drive_model #(.REV(REV)) u_drv (.clk, .rstn, .step_pulse, .step_dir, .spindle_motor_on,
        .mark_del, .crc_bad, .index_pulse_n, .track_zero_sense_n, .rd, .head, .pulses, .width,
        .setup, .gap);
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wv);
        @(posedge clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wv;
        do @(posedge clk); while (hready !== 1'h1);
        d = hrdata;
    endtask
    task automatic wirq(input int lim);
        t = 0;
        while (completion_interrupt !== 1'h1 && t < lim) begin
            @(posedge clk);
            t++;
        end
        chk(completion_interrupt, 1'h1);
    endtask
    task automatic run(input logic [7:0] c, input int lim, input logic [7:0] st);
        bus(1'h1, `FSR_CMD, {24'h0, c});
        wirq(lim);
        bus(1'h0, `FSR_STAT, 32'h0);
        chk(d, {24'h0, st});
    endtask
    // Sector read with the host taking each byte when take is set
    task automatic rds(input logic [7:0] s, input logic [7:0] c, input logic take,
        input logic [7:0] ns, input logic [7:0] st);
        int k;
        logic [7:0] e;
        k = 0;
        e = s;
        bus(1'h1, `FSR_SEC, {24'h0, s});
        bus(1'h1, `FSR_CMD, {24'h0, c});
        t = 0;
        while (completion_interrupt !== 1'h1 && t < 3 * REV) begin
            @(posedge clk);
            t++;
            if (take && byte_transfer_request === 1'h1) begin
                bus(1'h0, `FSR_DAT, 32'h0);
                chk(d, {24'h0, 8'(e * 16 + 3 + k)});
                k = (k + 1) % 4;
                if (k == 0)
                    e++;
            end
        end
        wirq(0);
        chk(e, s + ns);
        bus(1'h0, `FSR_STAT, 32'h0);
        chk(d, {24'h0, st});
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        complete_run();
    end
    initial begin
        {rstn, hsel, hwrite, htrans, haddr, hwdata, mark_del, crc_bad} = '0;
        hsize = 3'h2;
        err_count = 0;
        n_compared = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'h1;
        bus(1'h1, 8'h20, 32'hFF);
        bus(1'h1, `FSR_STAT, 32'hFF);
        bus(1'h0, `FSR_STAT, 32'h0);
        chk(d, 32'h0);
        bus(1'h0, 8'h20, 32'h0);
        chk(d, 32'h0);
        bus(1'h0, `FSR_CFG, 32'h0);
        chk(d, {24'h0, `FSR_SPT_RST});
        chk(hresp, 1'h0);
        $display("reset test done");
        bus(1'h1, `FSR_CMD, 32'h0);
        bus(1'h0, `FSR_STAT, 32'h0);
        chk(d, 32'h81);
        repeat (5 * REV) @(posedge clk);
        chk(pulses, 0);
        wirq(3 * REV);
        bus(1'h0, `FSR_STAT, 32'h0);
        chk(d, 32'h80);
        bus(1'h0, `FSR_TRK, 32'h0);
        chk(d, 32'h0);
        chk(pulses, 3);
        chk(width, 200);
        chk(setup >= 600, 1);
        $display("restore test done");
        bus(1'h1, `FSR_DAT, 32'h5);
        run(8'h1F, 3 * REV, 8'h80);
        bus(1'h0, `FSR_TRK, 32'h0);
        chk(d, 32'h5);
        chk(step_dir, 1'h1);
        chk(gap, R3 + 202);
        for (int i = 0; i < 3; i++) begin
            run(cmds[i], 2 * REV, 8'h80);
            bus(1'h0, `FSR_TRK, 32'h0);
            chk(d, {24'h0, trks[i]});
            chk(step_dir, dirs[i]);
            chk(setup >= 600, 1);
        end
        bus(1'h1, `FSR_CFG, 32'h90);
        run(8'h58, 2 * REV, 8'h80);
        chk(width, 100);
        bus(1'h1, `FSR_TRK, 32'h9);
        run(8'h4C, 7 * REV, 8'h90);
        bus(1'h1, `FSR_TRK, 32'h6);
        $display("positioning tests done");
        rds(8'h2, 8'h80, 1'h1, 8'h1, 8'h80);
        mark_del <= 1'h1;
        rds(8'h3, 8'h84, 1'h1, 8'h1, 8'hA0);
        mark_del <= 1'h0;
        rds(8'hF, 8'h98, 1'h1, 8'h2, 8'h80);
        bus(1'h0, `FSR_SEC, 32'h0);
        chk(d, 32'h10);
        crc_bad <= 1'h1;
        rds(8'h4, 8'h98, 1'h1, 8'h1, 8'h88);
        crc_bad <= 1'h0;
        bus(1'h0, `FSR_SEC, 32'h0);
        chk(d, 32'h4);
        rds(8'h6, 8'h88, 1'h0, 8'h0, 8'h86);
        bus(1'h0, `FSR_DAT, 32'h0);
        chk(d, 32'h63);
        bus(1'h1, `FSR_SEC, 32'h1);
        bus(1'h1, `FSR_CMD, 32'h98);
        bus(1'h1, `FSR_CMD, 32'hD0);
        wirq(10);
        bus(1'h0, `FSR_STAT, 32'h0);
        chk(d, 32'h80);
        bus(1'h1, `FSR_SEC, 32'h14);
        bus(1'h1, `FSR_CMD, 32'h88);
        bus(1'h0, `FSR_STAT, 32'h0);
        chk(d, 32'h81);
        repeat (3 * REV - 10) @(posedge clk);
        chk(completion_interrupt, 1'h0);
        wirq(2 * REV);
        bus(1'h0, `FSR_STAT, 32'h0);
        chk(d, 32'h90);
        $display("sector read tests done");
        repeat (8 * REV - 50) @(posedge clk);
        chk(spindle_motor_on, 1'h1);
        repeat (2 * REV) @(posedge clk);
        chk(spindle_motor_on, 1'h0);
        $display("motor test done");
        complete_run();
    end
endmodule // fsr_seq_tb

// >>> verilog/fsr_seq.sv
// Seek and sector read sequencer with an AHB-Lite register slave
// Assumes a separator on the same clock; drive pins index and track zero are asynchronous
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "fsr_map.svh"
module fsr_seq import fsr_pkg::*; #(
    parameter int SETTLE_CYC = `FSR_SETTLE_US * `FSR_CLK_MHZ,
    parameter int RATE0_CYC = `FSR_RATE0_US * `FSR_CLK_MHZ,
    parameter int RATE1_CYC = `FSR_RATE1_US * `FSR_CLK_MHZ,
    parameter int RATE2_CYC = `FSR_RATE2_US * `FSR_CLK_MHZ,
    parameter int RATE3_CYC = `FSR_RATE3_US * `FSR_CLK_MHZ,
    parameter logic [7:0] SPT_RST = `FSR_SPT_RST
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic index_pulse_n,
    input wire logic track_zero_sense_n,
    input wire fsr_rd_t rd,
    output logic step_pulse,
    output logic step_dir,
    output logic spindle_motor_on,
    output logic byte_transfer_request,
    output logic completion_interrupt
);
    localparam int PULSE_DD = `FSR_STEP_DD_US * `FSR_CLK_MHZ;
    localparam int PULSE_SD = `FSR_STEP_SD_US * `FSR_CLK_MHZ;
    localparam int DIRSU_CYC = `FSR_DIR_SU_US * `FSR_CLK_MHZ;

    function automatic logic [19:0] c20(input int n);
        c20 = n[19:0];
    endfunction

    fsr_state_t st;
    logic tz_s1, tz_s2, ix_s1, ix_s2, ix_s3;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [7:0] cmd, trk, sec, dat, cfg_spt;
    logic cfg_dd;
    logic busy, lost, crc, rnf, del, id_seen;
    logic [19:0] tmr;
    logic [3:0] rev;
    logic [7:0] scnt;
    logic [5:0] bcnt;

    // Track zero passes two flops, index three for its edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tz_s1 <= 1'b1;
            tz_s2 <= 1'b1;
            ix_s1 <= 1'b1;
            ix_s2 <= 1'b1;
            ix_s3 <= 1'b1;
        end else begin
            tz_s1 <= track_zero_sense_n;
            tz_s2 <= tz_s1;
            ix_s1 <= index_pulse_n;
            ix_s2 <= ix_s1;
            ix_s3 <= ix_s2;
        end
    end
    wire tz0 = !tz_s2;
    wire idx_edge = !ix_s2 && ix_s3;

    // Bus decode
    wire ap = hsel && htrans[1] && hready;
    wire [7:0] ra = haddr[7:0];
    wire rd_stat = ap && !hwrite && ra == `FSR_STAT;
    wire rd_data = ap && !hwrite && ra == `FSR_DAT;
    wire wr_cmd = wr_pend && wr_addr == `FSR_CMD;
    wire wr_trk = wr_pend && wr_addr == `FSR_TRK;
    wire wr_sec = wr_pend && wr_addr == `FSR_SEC;
    wire wr_dat = wr_pend && wr_addr == `FSR_DAT;
    wire wr_cfg = wr_pend && wr_addr == `FSR_CFG;
    wire [7:0] wb = hwdata[7:0];
    wire force_int = wr_cmd && wb[7:4] == 4'hD;
    wire cmd_go = wr_cmd && !force_int && st == S_IDLE;
    wire [7:0] stat_v = {spindle_motor_on, 1'b0, del, rnf, crc, lost,
        byte_transfer_request, busy};
    wire [7:0] rd_v = ra == `FSR_CMD ? cmd : ra == `FSR_STAT ? stat_v :
        ra == `FSR_TRK ? trk : ra == `FSR_SEC ? sec : ra == `FSR_DAT ? dat :
        ra == `FSR_CFG ? {cfg_dd, cfg_spt[6:0]} : 8'h00;

    // Command decode
    wire is_rst = cmd[7:4] == 4'h0;
    wire is_seek = cmd[7:4] == 4'h1;
    wire is_in = cmd[7:5] == 3'h2;
    wire is_out = cmd[7:5] == 3'h3;
    wire is_rd = cmd[7:5] == 3'h4;
    wire upd = is_seek || (!is_rst && cmd[4]);
    wire vfy = cmd[2];
    wire [19:0] rate_cyc = cmd[1:0] == 2'h0 ? c20(RATE0_CYC) :
        cmd[1:0] == 2'h1 ? c20(RATE1_CYC) :
        cmd[1:0] == 2'h2 ? c20(RATE2_CYC) : c20(RATE3_CYC);
    wire [19:0] pulse_cyc = cfg_dd ? c20(PULSE_DD) : c20(PULSE_SD);
    wire [5:0] win = cfg_dd ? `FSR_WIN_DD : `FSR_WIN_SD;
    wire id_hit = rd.id_stb && rd.id_trk == trk && rd.id_sec == sec;
    wire [3:0] srch_lim = id_seen ? `FSR_DAM_REVS : `FSR_ID_REVS;
    wire [7:0] trk_step = step_dir ? trk + 8'h01 : trk - 8'h01;
    wire fin_step = vfy;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= ap && hwrite;
            if (ap) begin
                wr_addr <= ra;
            end
            if (ap && !hwrite) begin
                hrdata <= {24'h00_0000, rd_v};
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st <= S_IDLE;
            cmd <= 8'h00;
            trk <= 8'h00;
            sec <= 8'h00;
            dat <= 8'h00;
            cfg_spt <= SPT_RST;
            cfg_dd <= 1'b0;
            busy <= 1'b0;
            lost <= 1'b0;
            crc <= 1'b0;
            rnf <= 1'b0;
            del <= 1'b0;
            id_seen <= 1'b0;
            tmr <= 20'h0_0000;
            rev <= 4'h0;
            scnt <= 8'h00;
            bcnt <= 6'h00;
            step_pulse <= 1'b0;
            step_dir <= 1'b0;
            spindle_motor_on <= 1'b0;
            byte_transfer_request <= 1'b0;
            completion_interrupt <= 1'b0;
        end else begin
            if (idx_edge) begin
                rev <= rev + 4'h1;
            end
            if (tmr != 20'h0_0000) begin
                tmr <= tmr - 20'h0_0001;
            end
            if (rd_data) begin
                byte_transfer_request <= 1'b0;
            end
            if (rd_stat || cmd_go) begin
                completion_interrupt <= 1'b0;
            end
            if (wr_trk) begin
                trk <= wb;
            end
            if (wr_sec) begin
                sec <= wb;
            end
            if (wr_dat) begin
                dat <= wb;
            end
            if (wr_cfg) begin
                cfg_dd <= wb[7];
                cfg_spt <= {1'b0, wb[6:0]};
            end
            unique case (st)
                S_IDLE: begin
                    if (spindle_motor_on && rev == `FSR_IDLE_REVS) begin
                        spindle_motor_on <= 1'b0;
                    end
                    if (cmd_go) begin
                        cmd <= wb;
                        busy <= 1'b1;
                        lost <= 1'b0;
                        crc <= 1'b0;
                        rnf <= 1'b0;
                        byte_transfer_request <= 1'b0;
                        if (!wb[3] && !spindle_motor_on) begin
                            spindle_motor_on <= 1'b1;
                            rev <= 4'h0;
                            st <= S_SPIN;
                        end else begin
                            st <= S_START;
                        end
                    end
                end
                S_SPIN: begin
                    if (rev == `FSR_SPIN_REVS) begin
                        st <= S_START;
                    end
                end
                S_START: begin
                    rev <= 4'h0;
                    id_seen <= 1'b0;
                    scnt <= 8'h00;
                    tmr <= c20(DIRSU_CYC);
                    if (is_rd) begin
                        st <= cmd[2] ? S_SETTLE : S_SEARCH;
                        tmr <= c20(SETTLE_CYC);
                    end else if (is_rst && tz0) begin
                        trk <= 8'h00;
                        st <= fin_step ? S_SETTLE : S_DONE;
                        tmr <= c20(SETTLE_CYC);
                    end else if (is_seek && trk == dat) begin
                        st <= fin_step ? S_SETTLE : S_DONE;
                        tmr <= c20(SETTLE_CYC);
                    end else begin
                        st <= S_DIRSU;
                        if (is_rst || is_out) begin
                            step_dir <= 1'b0;
                        end else if (is_in) begin
                            step_dir <= 1'b1;
                        end else if (is_seek) begin
                            step_dir <= dat > trk;
                        end
                    end
                end
                S_DIRSU: begin
                    if (tmr == 20'h0_0000) begin
                        step_pulse <= 1'b1;
                        tmr <= pulse_cyc - 20'h0_0001;
                        scnt <= scnt + 8'h01;
                        st <= S_PULSE;
                        if (upd) begin
                            trk <= trk_step;
                        end
                    end
                end
                S_PULSE: begin
                    if (tmr == 20'h0_0000) begin
                        step_pulse <= 1'b0;
                        tmr <= rate_cyc;
                        st <= S_RATE;
                    end
                end
                S_RATE: begin
                    if (tmr == 20'h0_0000) begin
                        tmr <= c20(SETTLE_CYC);
                        if (is_rst && tz0) begin
                            trk <= 8'h00;
                            st <= fin_step ? S_SETTLE : S_DONE;
                        end else if (is_rst && scnt == `FSR_RST_MAX) begin
                            rnf <= vfy;
                            st <= S_DONE;
                        end else if (is_rst || (is_seek && trk != dat)) begin
                            tmr <= 20'h0_0000;
                            st <= S_DIRSU;
                        end else begin
                            st <= fin_step ? S_SETTLE : S_DONE;
                        end
                    end
                end
                S_SETTLE: begin
                    if (tmr == 20'h0_0000) begin
                        rev <= 4'h0;
                        st <= is_rd ? S_SEARCH : S_VERIFY;
                    end
                end
                S_VERIFY: begin
                    if (rd.id_stb && rd.id_trk == trk && rd.id_crc_ok) begin
                        st <= S_DONE;
                    end else if (rd.id_stb && rd.id_trk == trk) begin
                        crc <= 1'b1;
                    end else if (rev == `FSR_VFY_REVS) begin
                        rnf <= 1'b1;
                        st <= S_DONE;
                    end
                end
                S_SEARCH: begin
                    if (id_hit && rd.id_crc_ok) begin
                        id_seen <= 1'b1;
                        bcnt <= 6'h00;
                        st <= S_DAM;
                    end else if (rev == srch_lim) begin
                        rnf <= 1'b1;
                        st <= S_DONE;
                    end else if (id_hit) begin
                        crc <= 1'b1;
                    end
                end
                S_DAM: begin
                    if (rd.mark_stb) begin
                        del <= rd.mark_deleted;
                        st <= S_DATA;
                    end else if (rev == `FSR_DAM_REVS) begin
                        rnf <= 1'b1;
                        st <= S_DONE;
                    end else if (rd.byte_stb) begin
                        bcnt <= bcnt + 6'h01;
                        if (bcnt == win - 6'h01) begin
                            st <= S_SEARCH;
                        end
                    end
                end
                S_DATA: begin
                    if (rd.byte_stb) begin
                        if (byte_transfer_request && !rd_data) begin
                            lost <= 1'b1;
                        end else begin
                            dat <= rd.byte_data;
                            byte_transfer_request <= 1'b1;
                        end
                    end
                    if (rd.end_stb) begin
                        if (!rd.end_crc_ok) begin
                            crc <= 1'b1;
                            st <= S_DONE;
                        end else if (cmd[4] && sec < cfg_spt) begin
                            sec <= sec + 8'h01;
                            rev <= 4'h0;
                            id_seen <= 1'b0;
                            st <= S_SEARCH;
                        end else begin
                            st <= S_DONE;
                        end
                    end
                end
                S_DONE: begin
                    busy <= 1'b0;
                    completion_interrupt <= 1'b1;
                    rev <= 4'h0;
                    st <= S_IDLE;
                end
            endcase
            if (force_int && st != S_IDLE) begin
                step_pulse <= 1'b0;
                st <= S_DONE;
            end
        end
    end

    // Helpers for the checks
    logic [19:0] pw, dir_age;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pw <= 20'h0_0000;
            dir_age <= 20'h0_0000;
        end else begin
            pw <= step_pulse ? pw + 20'h0_0001 : 20'h0_0000;
            dir_age <= $changed(step_dir) ? 20'h0_0000 :
                (&dir_age ? dir_age : dir_age + 20'h0_0001);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    step_width_a: assert property ($fell(step_pulse) |-> pw == pulse_cyc)
        else $error("step pulse width wrong");
    dir_setup_a: assert property ($rose(step_pulse) |-> dir_age >= c20(DIRSU_CYC))
        else $error("direction not settled before step");
    dir_in_a: assert property (st == S_PULSE && is_in |-> step_dir)
        else $error("step-in with direction low");
    spin_up_a: assert property (cmd_go && !wb[3] && !spindle_motor_on |=>
        spindle_motor_on && st == S_SPIN)
        else $error("spin-up not started");
    motor_on_a: assert property (cmd_go && spindle_motor_on |=> st == S_START)
        else $error("command delayed with motor on");
    motor_off_a: assert property (st == S_IDLE && !cmd_go && spindle_motor_on &&
        rev == `FSR_IDLE_REVS |=> !spindle_motor_on)
        else $error("motor not stopped after idle");
    lost_byte_a: assert property (st == S_DATA && rd.byte_stb &&
        byte_transfer_request && !rd_data |=> lost && $stable(dat))
        else $error("overrun not flagged");
    data_crc_a: assert property (st == S_DATA && rd.end_stb && !rd.end_crc_ok &&
        !force_int |=> crc ##1 completion_interrupt && !busy)
        else $error("data CRC error not terminating");
    rnf_a: assert property (st == S_SEARCH && rev == `FSR_ID_REVS && !id_seen &&
        !id_hit && !force_int |=> rnf ##1 completion_interrupt)
        else $error("record not found missing");
    busy_a: assert property (cmd_go |=> busy)
        else $error("busy not set on command");

    read_multi_c: cover property (st == S_DATA && rd.end_stb && cmd[4] ##1 st == S_SEARCH);
    spin_c: cover property (st == S_SPIN ##1 st == S_START);
    restore_c: cover property (st == S_RATE && is_rst && tz0 && tmr == 20'h0_0000);
endmodule // fsr_seq
